/* logic/fcs_defs.svh */
// Constants for the flash command sequencer host: offsets, fields, codes and timing
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets, byte addresses on AXI4-Lite
// ----------------------------------------------------------------------------
`define FCS_OFF_CTRL    6'h00
`define FCS_OFF_CFG     6'h04
`define FCS_OFF_ADDR    6'h08
`define FCS_OFF_WDATA   6'h0C
`define FCS_OFF_STATUS  6'h10
`define FCS_OFF_RDATA   6'h14

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FCS_CTRL_OP_LSB   0
`define FCS_CTRL_GO_BIT   8
`define FCS_CFG_BYTE_BIT  0
`define FCS_ST_BUSY_BIT   0
`define FCS_ST_DONE_BIT   1
`define FCS_ST_FAIL_BIT   2
`define FCS_ST_TOUT_BIT   3
`define FCS_CFG_RESET     1'b0
`define FCS_POLL_BIT      7
`define FCS_TOUT_BIT      5

// ----------------------------------------------------------------------------
// Flash bus codes
// ----------------------------------------------------------------------------
`define FCS_UNLOCK1_WORD  20'h00555
`define FCS_UNLOCK2_WORD  20'h002AA
`define FCS_UNLOCK1_BYTE  20'h00AAA
`define FCS_UNLOCK2_BYTE  20'h00555
`define FCS_CODE_UNLK1    8'hAA
`define FCS_CODE_UNLK2    8'h55
`define FCS_CODE_RESET    8'hF0
`define FCS_CODE_IDENT    8'h90
`define FCS_CODE_PROG     8'hA0
`define FCS_CODE_ERSETUP  8'h80
`define FCS_CODE_CHIPER   8'h10
`define FCS_CODE_SECTER   8'h30
`define FCS_CODE_SUSPEND  8'hB0
`define FCS_CODE_RESUME   8'h30

// ----------------------------------------------------------------------------
// Bus timing, nanoseconds, and derived clock counts at 100 MHz
// ----------------------------------------------------------------------------
`define FCS_CLK_NS        10
`define FCS_SETUP_NS      20
`define FCS_WE_NS         50
`define FCS_HOLD_NS       20
`define FCS_ACCESS_NS     70
`define FCS_SETUP_CYC     ((`FCS_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WE_CYC        ((`FCS_WE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_HOLD_CYC      ((`FCS_HOLD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACCESS_CYC    ((`FCS_ACCESS_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

/* logic/fcs_pkg.sv */
// Types for the flash command sequencer host
package fcs_pkg;

  // Operations software can launch through the control register
  typedef enum logic [3:0] {
    FCS_OP_READ     = 4'h0,
    FCS_OP_RESET    = 4'h1,
    FCS_OP_IDENT    = 4'h2,
    FCS_OP_PROGRAM  = 4'h3,
    FCS_OP_CHIP_ER  = 4'h4,
    FCS_OP_SECT_ER  = 4'h5,
    FCS_OP_SUSPEND  = 4'h6,
    FCS_OP_RESUME   = 4'h7
  } fcs_op_e;

  // Bus cycle timing states
  typedef enum logic [2:0] {
    FCS_ST_IDLE,
    FCS_ST_SETUP,
    FCS_ST_PULSE,
    FCS_ST_RECOV,
    FCS_ST_DECIDE
  } fcs_state_e;

  // What the current bus cycle is for
  typedef enum logic [2:0] {
    FCS_PH_CMD,
    FCS_PH_POLL,
    FCS_PH_RECHECK,
    FCS_PH_FINAL,
    FCS_PH_ABORT
  } fcs_phase_e;

endpackage

/* logic/fcs_sync.sv */
// Three-stage synchroniser for the flash data input bus
`timescale 1ns/10ps
module fcs_sync #(
  parameter int W = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_stage2,
  output logic      [W-1:0] o_stage3
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // First stage feeds only the second; callers compare stages two and three
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end
    else
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign o_stage2 = s2_reg;
  assign o_stage3 = s3_reg;

endmodule // fcs_sync

/* logic/fcs_host.sv */
// Host controller that drives a parallel NOR flash command bus from AXI4-Lite
//
// How it works
// - F0 write returns device to array read
// - Commands start with two unlock writes; reset, suspend and resume go out here as single writes
// - Unlock, 90, then read identification offset
// - Program: unlocks, A0, data at address
// - Erase: six writes, 10 or 30 last
// - Host polls at the programmed address
// - Host polls inside a selected sector
// - Valid data only from next read
// - Recheck polling bit after timeout bit
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_host #(
  parameter int AW        = 20,
  parameter int SETUP_CYC = `FCS_SETUP_CYC,
  parameter int WE_CYC    = `FCS_WE_CYC,
  parameter int HOLD_CYC  = `FCS_HOLD_CYC,
  parameter int ACC_CYC   = `FCS_ACCESS_CYC
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_resetn,
  // AXI4-Lite slave
  input  wire logic [5:0]    i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  input  wire logic [5:0]    i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  // Flash pins
  output logic [AW-1:0]      o_flash_addr,
  input  wire logic [15:0]   i_flash_dq,
  output logic [15:0]        o_flash_dq,
  output logic               o_flash_dq_oe,
  output logic               o_flash_ce_n,
  output logic               o_flash_we_n,
  output logic               o_flash_oe_n,
  output logic               o_flash_byte_n
);

  // --------------------------------------------------------------------------
  // Sequence table
  // --------------------------------------------------------------------------
  // One bus cycle: {is_read, address, data}. Upper data bits are driven zero
  // on command cycles since the device does not look at them.
  function automatic logic [AW+16:0] step(input fcs_pkg::fcs_op_e op,
                                           input logic [2:0] idx,
                                           input logic byte_m,
                                           input logic [AW-1:0] a,
                                           input logic [15:0] d);
    logic [AW-1:0] u1;
    logic [AW-1:0] u2;
    logic [7:0]    cmd;
    u1 = byte_m ? AW'(`FCS_UNLOCK1_BYTE) : AW'(`FCS_UNLOCK1_WORD);
    u2 = byte_m ? AW'(`FCS_UNLOCK2_BYTE) : AW'(`FCS_UNLOCK2_WORD);
    cmd = (op == fcs_pkg::FCS_OP_IDENT)   ? `FCS_CODE_IDENT :
          (op == fcs_pkg::FCS_OP_PROGRAM) ? `FCS_CODE_PROG  : `FCS_CODE_ERSETUP;
    step = {1'b0, u1, 8'h00, `FCS_CODE_UNLK1};
    case (op)
      fcs_pkg::FCS_OP_READ:    step = {1'b1, a, 16'h0000};
      fcs_pkg::FCS_OP_RESET:   step = {1'b0, a, 8'h00, `FCS_CODE_RESET};
      fcs_pkg::FCS_OP_SUSPEND: step = {1'b0, a, 8'h00, `FCS_CODE_SUSPEND};
      fcs_pkg::FCS_OP_RESUME:  step = {1'b0, a, 8'h00, `FCS_CODE_RESUME};
      default:
      begin
        case (idx)
          3'd0: step = {1'b0, u1, 8'h00, `FCS_CODE_UNLK1};
          3'd1: step = {1'b0, u2, 8'h00, `FCS_CODE_UNLK2};
          3'd2: step = {1'b0, u1, 8'h00, cmd};
          3'd3:
          begin
            if (op == fcs_pkg::FCS_OP_IDENT)
              step = {1'b1, a, 16'h0000};
            else if (op == fcs_pkg::FCS_OP_PROGRAM)
              step = {1'b0, a, d};
            else
              step = {1'b0, u1, 8'h00, `FCS_CODE_UNLK1};
          end
          3'd4:
          begin
            if (op == fcs_pkg::FCS_OP_IDENT)
              step = {1'b0, u1, 8'h00, `FCS_CODE_RESET};
            else
              step = {1'b0, u2, 8'h00, `FCS_CODE_UNLK2};
          end
          default:
          begin
            if (op == fcs_pkg::FCS_OP_CHIP_ER)
              step = {1'b0, u1, 8'h00, `FCS_CODE_CHIPER};
            else
              step = {1'b0, a, 8'h00, `FCS_CODE_SECTER};
          end
        endcase
      end
    endcase
  endfunction

  // Number of bus cycles in each command sequence
  function automatic logic [2:0] seq_len(input fcs_pkg::fcs_op_e op);
    case (op)
      fcs_pkg::FCS_OP_IDENT:   seq_len = 3'd5;
      fcs_pkg::FCS_OP_PROGRAM: seq_len = 3'd4;
      fcs_pkg::FCS_OP_CHIP_ER: seq_len = 3'd6;
      fcs_pkg::FCS_OP_SECT_ER: seq_len = 3'd6;
      default:                 seq_len = 3'd1;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  fcs_pkg::fcs_state_e st_reg,    st_next;
  fcs_pkg::fcs_phase_e ph_reg,    ph_next;
  fcs_pkg::fcs_op_e    op_reg,    op_next;
  logic [2:0]          idx_reg,   idx_next;
  logic [7:0]          cnt_reg,   cnt_next;
  logic [AW+16:0]      cyc_reg,   cyc_next;
  logic [15:0]         rd_reg,    rd_next;
  logic                byte_reg,  byte_next;
  logic [AW-1:0]       addr_reg,  addr_next;
  logic [15:0]         wd_reg,    wd_next;
  logic                done_reg,  done_next;
  logic                fail_reg,  fail_next;
  logic                tout_reg,  tout_next;
  logic                bv_reg,    bv_next;
  logic [1:0]          br_reg,    br_next;
  logic                rv_reg,    rv_next;
  logic [31:0]         rdat_reg,  rdat_next;
  logic [1:0]          rr_reg,    rr_next;
  logic [15:0]         dq_s2;
  logic [15:0]         dq_s3;
  logic                wr_fire;
  logic                rd_fire;
  logic                go;
  logic                busy;
  logic                poll_ok;

  fcs_sync #(
    .W (16)
  ) u_dq_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_flash_dq),
    .o_stage2  (dq_s2),
    .o_stage3  (dq_s3)
  );

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  // Address and data are taken together, so either arrival order works
  assign busy      = (st_reg != fcs_pkg::FCS_ST_IDLE);
  assign wr_fire   = i_awvalid && i_wvalid && !bv_reg;
  assign rd_fire   = i_arvalid && !rv_reg;
  assign o_awready = wr_fire;
  assign o_wready  = wr_fire;
  assign o_arready = rd_fire;
  assign o_bvalid  = bv_reg;
  assign o_bresp   = br_reg;
  assign o_rvalid  = rv_reg;
  assign o_rdata   = rdat_reg;
  assign o_rresp   = rr_reg;
  // A launch while busy is dropped so no command lands mid-algorithm
  assign go = wr_fire && (i_awaddr == `FCS_OFF_CTRL) && i_wstrb[1] &&
              i_wdata[`FCS_CTRL_GO_BIT] && !busy;

  // Register writes, responses and read data
  always_comb
  begin
    bv_next   = bv_reg;
    br_next   = br_reg;
    rv_next   = rv_reg;
    rdat_next = rdat_reg;
    rr_next   = rr_reg;
    byte_next = byte_reg;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    if (bv_reg && i_bready)
      bv_next = 1'b0;
    if (rv_reg && i_rready)
      rv_next = 1'b0;
    if (wr_fire)
    begin
      bv_next = 1'b1;
      br_next = 2'b00;
      case (i_awaddr)
        `FCS_OFF_CTRL, `FCS_OFF_STATUS, `FCS_OFF_RDATA: ;
        `FCS_OFF_CFG:
          if (i_wstrb[0] && !busy)
            byte_next = i_wdata[`FCS_CFG_BYTE_BIT];
        `FCS_OFF_ADDR:
          if (!busy)
            addr_next = i_wdata[AW-1:0];
        `FCS_OFF_WDATA:
          if (!busy)
            wd_next = i_wdata[15:0];
        default: br_next = 2'b10;
      endcase
    end
    if (rd_fire)
    begin
      rv_next = 1'b1;
      rr_next = 2'b00;
      case (i_araddr)
        `FCS_OFF_CTRL:   rdat_next = {28'h0000000, op_reg};
        `FCS_OFF_CFG:    rdat_next = {31'h00000000, byte_reg};
        `FCS_OFF_ADDR:   rdat_next = {{(32-AW){1'b0}}, addr_reg};
        `FCS_OFF_WDATA:  rdat_next = {16'h0000, wd_reg};
        `FCS_OFF_STATUS: rdat_next = {28'h0000000, tout_reg, fail_reg, done_reg, busy};
        `FCS_OFF_RDATA:  rdat_next = {16'h0000, rd_reg};
        default:
        begin
          rdat_next = 32'h00000000;
          rr_next   = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      bv_reg   <= 1'b0;
      br_reg   <= 2'b00;
      rv_reg   <= 1'b0;
      rdat_reg <= 32'h00000000;
      rr_reg   <= 2'b00;
      byte_reg <= `FCS_CFG_RESET;
      addr_reg <= '0;
      wd_reg   <= 16'h0000;
    end
    else
    begin
      bv_reg   <= bv_next;
      br_reg   <= br_next;
      rv_reg   <= rv_next;
      rdat_reg <= rdat_next;
      rr_reg   <= rr_next;
      byte_reg <= byte_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
    end
  end

  // --------------------------------------------------------------------------
  // Flash bus sequencer
  // --------------------------------------------------------------------------
  // Program expects true bit seven of its data; erase expects a one
  assign poll_ok = (op_reg == fcs_pkg::FCS_OP_PROGRAM) ?
                   (rd_reg[`FCS_POLL_BIT] == wd_reg[`FCS_POLL_BIT]) :
                   rd_reg[`FCS_POLL_BIT];

  // Cycle timing and the decision after every bus cycle
  always_comb
  begin
    st_next   = st_reg;
    ph_next   = ph_reg;
    op_next   = op_reg;
    idx_next  = idx_reg;
    cnt_next  = cnt_reg;
    cyc_next  = cyc_reg;
    rd_next   = rd_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    tout_next = tout_reg;
    case (st_reg)
      fcs_pkg::FCS_ST_IDLE:
        if (go)
        begin
          op_next   = fcs_pkg::fcs_op_e'(i_wdata[`FCS_CTRL_OP_LSB +: 4]);
          ph_next   = fcs_pkg::FCS_PH_CMD;
          idx_next  = 3'd0;
          cyc_next  = step(fcs_pkg::fcs_op_e'(i_wdata[`FCS_CTRL_OP_LSB +: 4]), 3'd0,
                           byte_reg, addr_reg, wd_reg);
          cnt_next  = 8'(SETUP_CYC);
          done_next = 1'b0;
          fail_next = 1'b0;
          tout_next = 1'b0;
          st_next   = fcs_pkg::FCS_ST_SETUP;
        end
      fcs_pkg::FCS_ST_SETUP:
        if (cnt_reg <= 8'd1)
        begin
          // Write strobe falls after chip select, so it is the later edge
          cnt_next = cyc_reg[AW+16] ? 8'(ACC_CYC) : 8'(WE_CYC);
          st_next  = fcs_pkg::FCS_ST_PULSE;
        end
        else
          cnt_next = cnt_reg - 8'd1;
      fcs_pkg::FCS_ST_PULSE:
        if (cnt_reg > 8'd1)
          cnt_next = cnt_reg - 8'd1;
        else if (!cyc_reg[AW+16])
        begin
          // Write strobe rises first; data held past it through recovery
          cnt_next = 8'(HOLD_CYC);
          st_next  = fcs_pkg::FCS_ST_RECOV;
        end
        else if (dq_s2 == dq_s3)
        begin
          // Read sampled only once the synchronised bus is steady
          rd_next  = dq_s3;
          cnt_next = 8'(HOLD_CYC);
          st_next  = fcs_pkg::FCS_ST_RECOV;
        end
      fcs_pkg::FCS_ST_RECOV:
        if (cnt_reg <= 8'd1)
          st_next = fcs_pkg::FCS_ST_DECIDE;
        else
          cnt_next = cnt_reg - 8'd1;
      fcs_pkg::FCS_ST_DECIDE:
      begin
        st_next  = fcs_pkg::FCS_ST_SETUP;
        cnt_next = 8'(SETUP_CYC);
        case (ph_reg)
          fcs_pkg::FCS_PH_CMD:
            if (idx_reg + 3'd1 < seq_len(op_reg))
            begin
              idx_next = idx_reg + 3'd1;
              cyc_next = step(op_reg, idx_reg + 3'd1, byte_reg, addr_reg, wd_reg);
            end
            else if (op_reg == fcs_pkg::FCS_OP_PROGRAM ||
                     op_reg == fcs_pkg::FCS_OP_CHIP_ER ||
                     op_reg == fcs_pkg::FCS_OP_SECT_ER)
            begin
              // Polling starts only after the last write strobe has risen
              ph_next  = fcs_pkg::FCS_PH_POLL;
              cyc_next = {1'b1, addr_reg, 16'h0000};
            end
            else
            begin
              done_next = 1'b1;
              st_next   = fcs_pkg::FCS_ST_IDLE;
            end
          fcs_pkg::FCS_PH_POLL:
            if (poll_ok)
              ph_next = fcs_pkg::FCS_PH_FINAL;
            else if (rd_reg[`FCS_TOUT_BIT])
            begin
              tout_next = 1'b1;
              ph_next   = fcs_pkg::FCS_PH_RECHECK;
            end
          fcs_pkg::FCS_PH_RECHECK:
            if (poll_ok)
              ph_next = fcs_pkg::FCS_PH_FINAL;
            else
            begin
              // Failed operation: a reset write brings back array reads
              ph_next  = fcs_pkg::FCS_PH_ABORT;
              cyc_next = {1'b0, addr_reg, 8'h00, `FCS_CODE_RESET};
            end
          fcs_pkg::FCS_PH_ABORT:
          begin
            fail_next = 1'b1;
            done_next = 1'b1;
            st_next   = fcs_pkg::FCS_ST_IDLE;
          end
          default:
          begin
            // Read after the poll turned true carries trustworthy data
            done_next = 1'b1;
            st_next   = fcs_pkg::FCS_ST_IDLE;
          end
        endcase
      end
      default: st_next = fcs_pkg::FCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_resetn)
    begin
      st_reg   <= fcs_pkg::FCS_ST_IDLE;
      ph_reg   <= fcs_pkg::FCS_PH_CMD;
      op_reg   <= fcs_pkg::FCS_OP_READ;
      idx_reg  <= 3'd0;
      cnt_reg  <= 8'h00;
      cyc_reg  <= '0;
      rd_reg   <= 16'h0000;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      tout_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      ph_reg   <= ph_next;
      op_reg   <= op_next;
      idx_reg  <= idx_next;
      cnt_reg  <= cnt_next;
      cyc_reg  <= cyc_next;
      rd_reg   <= rd_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      tout_reg <= tout_next;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  // Chip select spans setup to recovery so both strobe edges fall inside it
  assign o_flash_addr   = cyc_reg[AW+15:16];
  assign o_flash_dq     = cyc_reg[15:0];
  assign o_flash_dq_oe  = !cyc_reg[AW+16] && (st_reg == fcs_pkg::FCS_ST_PULSE ||
                                              st_reg == fcs_pkg::FCS_ST_RECOV);
  assign o_flash_ce_n   = !(st_reg == fcs_pkg::FCS_ST_SETUP ||
                            st_reg == fcs_pkg::FCS_ST_PULSE ||
                            st_reg == fcs_pkg::FCS_ST_RECOV);
  assign o_flash_we_n   = !(st_reg == fcs_pkg::FCS_ST_PULSE && !cyc_reg[AW+16]);
  assign o_flash_oe_n   = !(st_reg == fcs_pkg::FCS_ST_PULSE && cyc_reg[AW+16]);
  assign o_flash_byte_n = !byte_reg;

endmodule // fcs_host

/* verification/fcs_host_checker.sv */
// Checker for the flash strobe timing of fcs_host
`timescale 1ns/10ps
module fcs_host_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic o_flash_ce_n,
  input wire logic o_flash_we_n,
  input wire logic o_flash_oe_n,
  input wire logic o_flash_dq_oe
);
  // ---------------------------------------------------------------
  // Bus cycle shape
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Address settles under chip select before any strobe
  ce_setup_a: assert property ($fell(o_flash_ce_n) |-> (o_flash_we_n && o_flash_oe_n) [*2])
    else $error("strobe too soon after select");
  // Write pulse width, then data still driven after the strobe rises
  we_width_a: assert property ($fell(o_flash_we_n) |-> (!o_flash_we_n && !o_flash_ce_n) [*5]
    ##1 (o_flash_we_n && !o_flash_ce_n && o_flash_dq_oe))
    else $error("write pulse shape wrong");
  read_len_a: assert property ($fell(o_flash_oe_n) |-> (!o_flash_oe_n) [*7])
    else $error("read strobe too short");
  read_recov_a: assert property ($rose(o_flash_oe_n) |-> !o_flash_ce_n)
    else $error("select dropped with read strobe");
  strobe_excl_a: assert property (o_flash_we_n || o_flash_oe_n)
    else $error("read and write strobes together");
  read_float_a: assert property (!o_flash_oe_n |-> !o_flash_dq_oe)
    else $error("host drives data during read");
  strobe_ce_a: assert property (!o_flash_we_n || !o_flash_oe_n |-> !o_flash_ce_n)
    else $error("strobe without select");
  bus_release_a: assert property ($rose(o_flash_ce_n) |-> o_flash_we_n && o_flash_oe_n)
    else $error("strobe held past cycle end");
  cover property ($rose(o_flash_we_n));
  cover property ($rose(o_flash_oe_n));
  cover property ($rose(o_flash_ce_n));
endmodule // fcs_host_checker

bind fcs_host fcs_host_checker fcs_host_checker_i (.i_sys_clk, .i_resetn, .o_flash_ce_n,
  .o_flash_we_n, .o_flash_oe_n, .o_flash_dq_oe);

/* verification/fcs_flash_model.sv */
// Behavioural parallel flash device, word mode only
`timescale 1ns/10ps
module fcs_flash_model #(
  parameter logic [15:0] MAKER    = 16'h00A5, // Arbitrary identity value
  parameter logic [15:0] PART     = 16'h5A3C, // Arbitrary identity value
  parameter int          PROG_NS  = 2000,
  parameter int          ERASE_NS = 5000
) (
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic      [15:0] o_dq
);
  logic [15:0] mem [0:255];
  logic [19:0] pa;
  logic [7:0]  d;
  logic [7:0]  pv = 8'h00;
  logic        idm = 1'b0;
  logic        busy = 1'b0;
  logic        ers = 1'b0;
  logic        tf = 1'b0;
  int          st = 0;
  wire         wr = i_we_n | i_ce_n;
  wire  [10:0] la = pa[10:0]; // Upper address bits ignored in commands
  wire         pr = &pa[7:4]; // Top sixteen words form a locked sector
  initial foreach (mem[k]) mem[k] = 16'hFFFF;
  always @(negedge wr) pa = i_addr;
  // Decode on the first rising strobe; upper data lines dropped
  always @(posedge wr)
  begin
    d = i_dq[7:0];
    if (busy && !tf) st = 0;
    else if (d == 8'hF0) begin st = 0; idm = 1'b0; tf = 1'b0; busy <= 1'b0; end
    else case (st) // B0 and 30 alone fall through, no erase to suspend
      0: st = (la == 11'h555 && d == 8'hAA) ? 1 : 0;
      1: st = (la == 11'h2AA && d == 8'h55) ? 2 : 0;
      2: begin
        idm = (la == 11'h555 && d == 8'h90);
        st = la != 11'h555 ? 0 : d == 8'hA0 ? 6 : d == 8'h80 ? 3 : 0;
      end
      3: st = (la == 11'h555 && d == 8'hAA) ? 4 : 0;
      4: st = (la == 11'h2AA && d == 8'h55) ? 5 : 0;
      5: begin
        if (d == 8'h30 || (d == 8'h10 && la == 11'h555))
        begin
          foreach (mem[k]) if (k < 240) mem[k] = 16'hFFFF; // Locked sector survives
          ers = 1'b1;
          busy <= 1'b1;
          busy <= #(ERASE_NS) 1'b0;
        end
        st = 0;
      end
      6: begin
        // A zero cannot return to one: the algorithm stalls until a reset write
        tf = !pr && ((i_dq & ~mem[pa[7:0]]) != 16'h0000);
        if (!pr) mem[pa[7:0]] = mem[pa[7:0]] & i_dq;
        pv = d;
        ers = 1'b0;
        busy <= 1'b1;
        if (!tf) busy <= #(PROG_NS) 1'b0;
        st = 0;
      end
      default: st = 0;
    endcase
  end
  // Status while busy, identity codes or array; inverted pattern when deselected
  wire [15:0] rv = busy ? {8'h00, ers ? 1'b0 : ~pv[7], 1'b0, tf, 5'h00}
    : idm ? (i_addr[1:0] == 2'h0 ? MAKER : i_addr[1:0] == 2'h1 ? PART
    : {15'h0000, &i_addr[7:4]})
    : mem[i_addr[7:0]];
  assign o_dq = (i_ce_n | i_oe_n) ? ~rv : rv;
endmodule // fcs_flash_model

/* verification/fcs_host_bench.sv */
// Self-checking bench for fcs_host against the flash device model
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_host_bench;
  logic        i_sys_clk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic        i_arvalid = 0, i_rready = 0;
  logic [5:0]  i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, o_rdata, v;
  logic [3:0]  i_wstrb = 4'hF;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_flash_byte_n;
  logic        o_flash_dq_oe, o_flash_ce_n, o_flash_we_n, o_flash_oe_n;
  logic [1:0]  o_bresp, o_rresp, r;
  logic [19:0] o_flash_addr;
  logic [15:0] o_flash_dq;
  wire  [15:0] dev_dq;
  wire  [15:0] i_flash_dq = o_flash_dq_oe ? o_flash_dq : dev_dq;
  int          failures = 0, samples_checked = 0, cyc = 0;
  fcs_host fcs_host_i (.*);
  fcs_flash_model fcs_flash_model_i (.i_addr(o_flash_addr), .i_dq(i_flash_dq),
    .i_ce_n(o_flash_ce_n), .i_we_n(o_flash_we_n), .i_oe_n(o_flash_oe_n), .o_dq(dev_dq));
  // ---------------------------------------------------------------
  // Clock, timeout and report
  // ---------------------------------------------------------------
  initial forever #5 i_sys_clk = ~i_sys_clk;
  // Whole run needs well under half of this ceiling
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 40000) begin failures++; end_sim(); end
  end
  task end_sim();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin failures++; $display("mismatch at %0t: saw %h want %h", $time, s, e); end
  endtask
  // ---------------------------------------------------------------
  // AXI4-Lite master; nonblocking drives at the rising edge keep strobes from racing the clock
  // ---------------------------------------------------------------
  task wr(input logic [5:0] a, input logic [31:0] d);
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    @(posedge i_sys_clk);
    while (o_awready !== 1) @(posedge i_sys_clk);
    i_awvalid <= 0; i_wvalid <= 0;
    @(posedge i_sys_clk);
    while (o_bvalid !== 1) @(posedge i_sys_clk);
    r = o_bresp; i_bready <= 0;
    @(posedge i_sys_clk);
  endtask
  task rd(input logic [5:0] a);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    @(posedge i_sys_clk);
    while (o_arready !== 1) @(posedge i_sys_clk);
    i_arvalid <= 0;
    @(posedge i_sys_clk);
    while (o_rvalid !== 1) @(posedge i_sys_clk);
    v = o_rdata; r = o_rresp; i_rready <= 0;
    @(posedge i_sys_clk);
  endtask
  task rdchk(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  // Launch one operation and wait for busy to clear
  task op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] w,
    input logic [31:0] s = 32'h2);
    wr(`FCS_OFF_ADDR, {12'h000, a});
    wr(`FCS_OFF_WDATA, {16'h0000, w});
    wr(`FCS_OFF_CTRL, {23'h000000, 1'b1, 4'h0, o});
    v = 32'h1;
    while (v[0] !== 1'b0) rd(`FCS_OFF_STATUS);
    chk(v, s);
  endtask
  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1;
    @(posedge i_sys_clk);
    rdchk(`FCS_OFF_CFG, 32'h0);
    wr(`FCS_OFF_CFG, 32'h1);
    chk({31'h0, o_flash_byte_n}, 32'h0);
    rdchk(`FCS_OFF_CFG, 32'h1);
    wr(`FCS_OFF_CFG, 32'h0);
    wr(6'h18, 32'h0);
    chk({30'h0, r}, 32'h2);
    rdchk(6'h18, 32'h0);
    chk({30'h0, r}, 32'h2);
    op(4'h3, 20'h00010, 16'h0055);
    rdchk(`FCS_OFF_RDATA, 32'h55);
    op(4'h3, 20'hFF010, 16'h0005);
    rdchk(`FCS_OFF_RDATA, 32'h05);
    op(4'h2, 20'h0, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'h00A5);
    op(4'h2, 20'h1, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'h5A3C);
    op(4'h2, 20'h2, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'h0);
    op(4'h2, 20'hF2, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'h1);
    op(4'h0, 20'h00010, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'h05);
    op(4'h3, 20'h00010, 16'h00FF, 32'hE);
    op(4'h0, 20'h00010, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'h05);
    op(4'h5, 20'h00010, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'hFFFF);
    op(4'h3, 20'h00010, 16'h00AA);
    for (int o = 6; o > 0; o = (o == 7) ? 1 : (o == 1) ? 0 : 7)
      op(o[3:0], 20'h10, 16'h0);
    op(4'h0, 20'h00010, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'hAA);
    op(4'h4, 20'h00010, 16'h0);
    rdchk(`FCS_OFF_RDATA, 32'hFFFF);
    end_sim();
  end
endmodule // fcs_host_bench
